// file: core/trs_supervisor.sv
// Reset and power-fail supervisor logic with selectable release timeout
`timescale 1ns/100ps

module trs_supervisor
  import trs_pkg::*;
#(
  parameter int INT_CYCLES = INT_TIMEOUT_CYC,
  parameter int MIN_CYCLES = MIN_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire trs_monitors_t monitors_i,
  input wire trs_pf_sense_t pf_sense_i,
  input wire trs_tmo_mode_t timeout_select_i,
  input wire logic [15:0] timeout_capacitor_i,
  output logic supply_reset_n_o,
  output logic power_fail_warn_n_o
);

  // ----------------------------------------------------------------
  // Timeout selection
  // ----------------------------------------------------------------
  function automatic logic [31:0] timeout_cycles(
    input trs_tmo_mode_t mode,
    input logic [15:0] cap_pf
  );
    logic [31:0] cyc;
    cyc = 32'(MIN_CYCLES);
    case (mode)
      TMO_INTERNAL: cyc = 32'(INT_CYCLES);
      TMO_CAPACITOR: begin
        if (cap_pf != 16'h0) begin
          cyc = 32'(cap_pf) * 32'(CAP_CYC_PER_PF);
        end
      end
      default: cyc = 32'(MIN_CYCLES);
    endcase
    if (cyc == 32'h0) begin
      cyc = 32'h1;
    end
    return cyc;
  endfunction

  logic all_ok;
  logic latched;
  logic [31:0] limit;

  assign all_ok = &monitors_i;
  assign latched = (timeout_select_i == TMO_LATCH);
  assign limit = timeout_cycles(timeout_select_i, timeout_capacitor_i);

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  trs_state_t state;
  trs_state_t next_state;
  logic [31:0] count;
  logic [31:0] next_count;
  logic next_reset_n;

  always_comb begin
    next_state = state;
    next_count = count;
    next_reset_n = supply_reset_n_o;
    if (latched) begin
      next_count = 32'h0;
    end else begin
      case (state)
        ST_HOLD: begin
          next_reset_n = 1'h0;
          next_count = 32'h0;
          if (all_ok) begin
            next_state = ST_TIMING;
          end
        end
        ST_TIMING: begin
          if (!all_ok) begin
            next_state = ST_HOLD;
            next_count = 32'h0;
            next_reset_n = 1'h0;
          end else if (count >= limit - 32'h1) begin
            next_state = ST_RELEASED;
            next_count = 32'h0;
            next_reset_n = 1'h1;
          end else begin
            next_count = count + 32'h1;
          end
        end
        ST_RELEASED: begin
          if (!all_ok) begin
            next_state = ST_HOLD;
            next_reset_n = 1'h0;
          end
        end
        default: begin
          next_state = ST_HOLD;
          next_count = 32'h0;
          next_reset_n = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= ST_HOLD;
      count <= 32'h0;
      supply_reset_n_o <= RESET_N_RST;
    end else begin
      state <= next_state;
      count <= next_count;
      supply_reset_n_o <= next_reset_n;
    end
  end

  // ----------------------------------------------------------------
  // Power-fail comparator with hysteresis
  // ----------------------------------------------------------------
  logic next_warn_n;

  always_comb begin
    next_warn_n = power_fail_warn_n_o;
    if (!pf_sense_i.above_fall) begin
      next_warn_n = 1'h0;
    end else if (pf_sense_i.above_rise) begin
      next_warn_n = 1'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      power_fail_warn_n_o <= WARN_N_RST;
    end else begin
      power_fail_warn_n_o <= next_warn_n;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  monitor_low_a: assert property (
    !all_ok && !latched |=> !supply_reset_n_o
  ) else $error("reset not asserted on low monitor");

  release_time_a: assert property (
    $rose(supply_reset_n_o) |->
      $past(state) == ST_TIMING && $past(count) == $past(limit) - 32'h1
      && $past(all_ok)
  ) else $error("reset released before timeout");

  internal_limit_a: assert property (
    $rose(supply_reset_n_o) && $past(timeout_select_i) == TMO_INTERNAL
      |-> $past(count) == 32'(INT_CYCLES - 1)
  ) else $error("internal timeout wrong");

  cap_limit_a: assert property (
    $rose(supply_reset_n_o) && $past(timeout_select_i) == TMO_CAPACITOR
      && $past(timeout_capacitor_i) == 16'h1
      |-> $past(count) == 32'(CAP_CYC_PER_PF) - 32'h1
  ) else $error("capacitor timeout scale wrong");

  open_limit_a: assert property (
    $rose(supply_reset_n_o) && $past(timeout_select_i) == TMO_OPEN
      |-> $past(count) == 32'(MIN_CYCLES - 1)
  ) else $error("open timeout wrong");

  latch_hold_a: assert property (
    latched |=> $stable(supply_reset_n_o) && $stable(state)
  ) else $error("reset changed while latched");

  pf_fall_a: assert property (
    !pf_sense_i.above_fall |=> !power_fail_warn_n_o
  ) else $error("warning not asserted below falling level");

  pf_band_a: assert property (
    pf_sense_i.above_fall && !pf_sense_i.above_rise
      |=> $stable(power_fail_warn_n_o)
  ) else $error("warning changed inside hysteresis band");

  pf_rise_a: assert property (
    pf_sense_i.above_fall && pf_sense_i.above_rise |=> power_fail_warn_n_o
  ) else $error("warning not released above rising level");

  pf_indep_a: assert property (
    !pf_sense_i.above_fall && supply_reset_n_o && all_ok && !latched
      |=> !power_fail_warn_n_o && supply_reset_n_o
  ) else $error("warning not independent of reset");

  timing_start_a: assert property (
    state == ST_HOLD && all_ok && !latched
      |=> state == ST_TIMING && count == 32'h0 && !supply_reset_n_o
  ) else $error("timeout did not start");

  timing_drop_a: assert property (
    state == ST_TIMING && !all_ok && !latched
      |=> state == ST_HOLD ##1 count == 32'h0
  ) else $error("timeout not restarted after drop");

  latch_exit_a: assert property (
    $past(latched) && !latched && !all_ok |=> !supply_reset_n_o
  ) else $error("evaluation not resumed after latch");

  release_c: cover property ($rose(supply_reset_n_o));
  pf_warn_c: cover property ($fell(power_fail_warn_n_o) && supply_reset_n_o);
  latch_c: cover property (latched && supply_reset_n_o ##1 !all_ok);
  restart_c: cover property (state == ST_TIMING ##1 state == ST_HOLD);

endmodule

// file: core/trs_pkg.sv
// Shared types and constants of the triple supply reset supervisor
package trs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 250000;
  localparam int INT_TIMEOUT_MS = 200;
  localparam int MIN_TIMEOUT_US = 400;
  localparam int CAP_NS_PER_PF = 9400;
  localparam int INT_TIMEOUT_CYC = INT_TIMEOUT_MS * CLK_KHZ;
  localparam int MIN_TIMEOUT_CYC = (MIN_TIMEOUT_US * CLK_KHZ) / 1000;
  localparam logic [11:0] CAP_CYC_PER_PF =
    12'((CAP_NS_PER_PF * (CLK_KHZ / 1000)) / 1000);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RESET_N_RST = 1'h0;
  localparam logic WARN_N_RST = 1'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic primary_supply_monitor;
    logic secondary_supply_monitor;
    logic adjustable_monitor;
  } trs_monitors_t;

  typedef struct packed {
    logic above_fall;
    logic above_rise;
  } trs_pf_sense_t;

  typedef enum logic [1:0] {
    TMO_INTERNAL = 2'h0,
    TMO_CAPACITOR = 2'h1,
    TMO_OPEN = 2'h2,
    TMO_LATCH = 2'h3
  } trs_tmo_mode_t;

  typedef enum logic [2:0] {
    ST_HOLD = 3'h1,
    ST_TIMING = 3'h2,
    ST_RELEASED = 3'h4
  } trs_state_t;

endpackage

// file: sim/trs_host_model.sv
// Host model watching the early power-fail warning (its reset input is left unused)
`timescale 1ns/100ps

module trs_host_model (
  input wire logic clk_i,
  input wire logic supply_reset_n_i,
  input wire logic power_fail_warn_n_i
);
  int shutdowns = 0;
  logic warn_q = 1'h0;
  // Falling warning taken as a non-maskable shutdown request
  always @(posedge clk_i) begin
    warn_q <= power_fail_warn_n_i;
    if (warn_q === 1'h1 && power_fail_warn_n_i === 1'h0) begin
      shutdowns <= shutdowns + 1;
    end
  end
endmodule

// file: sim/trs_supervisor_test.sv
// Self-checking bench of the triple supply reset supervisor
`timescale 1ns/100ps

module trs_supervisor_test;
  import trs_pkg::*;
  localparam int INT_C = 20;
  localparam int MIN_C = 8;
  logic clk_i, rst_n_i, supply_reset_n_o, power_fail_warn_n_o;
  trs_monitors_t monitors_i;
  trs_pf_sense_t pf_sense_i;
  trs_tmo_mode_t timeout_select_i;
  logic [15:0] timeout_capacitor_i;
  int error_cnt, comparisons, seed, n;
  logic [2:0] bad;
  logic [1:0] pf_seq [5] = '{2'h0, 2'h2, 2'h3, 2'h2, 2'h0};
  logic warn_exp [5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0};

  trs_supervisor #(.INT_CYCLES(INT_C), .MIN_CYCLES(MIN_C)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .monitors_i(monitors_i),
    .pf_sense_i(pf_sense_i), .timeout_select_i(timeout_select_i),
    .timeout_capacitor_i(timeout_capacitor_i),
    .supply_reset_n_o(supply_reset_n_o),
    .power_fail_warn_n_o(power_fail_warn_n_o));

  trs_host_model host (.clk_i(clk_i), .supply_reset_n_i(supply_reset_n_o),
    .power_fail_warn_n_i(power_fail_warn_n_o));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic int limit(trs_tmo_mode_t m, logic [15:0] c);
    if (m == TMO_INTERNAL) return INT_C;
    if (m == TMO_CAPACITOR && c != 16'h0000) return int'(c) * 2350;
    return MIN_C;
  endfunction

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // All monitors good from this edge, count edges until release
  task automatic release_after(input trs_tmo_mode_t m, input logic [15:0] c);
    timeout_select_i = m;
    timeout_capacitor_i = c;
    monitors_i = 3'h7;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (supply_reset_n_o !== 1'h1 && n < limit(m, c) + 9);
    check(n == limit(m, c) + 1, 1'h1, "release delay");
    if (n >= limit(m, c) + 9) results();
  endtask

  task automatic drop();
    bad = 3'($random(seed)) & 3'h6;
    monitors_i = bad;
    @(negedge clk_i);
    check(supply_reset_n_o, 1'h0, "reset on drop");
  endtask

  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    seed = 32'h1D9BC206;
    error_cnt = 0;
    comparisons = 0;
    rst_n_i = 1'h0;
    monitors_i = 3'h0;
    pf_sense_i = 2'h3;
    timeout_select_i = TMO_INTERNAL;
    timeout_capacitor_i = 16'h0000;
    repeat (2) @(negedge clk_i);
    check(supply_reset_n_o, 1'h0, "reset value");
    check(power_fail_warn_n_o, 1'h0, "warn reset value");
    rst_n_i = 1'h1;
    $display("test reset done");
    release_after(TMO_INTERNAL, 16'($random(seed)));
    drop();
    release_after(TMO_OPEN, 16'($random(seed)));
    drop();
    release_after(TMO_CAPACITOR, 16'h0000);
    drop();
    release_after(TMO_CAPACITOR, 16'h0001);
    drop();
    $display("test timeout modes done");
    monitors_i = 3'h7;
    timeout_select_i = TMO_INTERNAL;
    repeat (3 + ($random(seed) & 7)) @(negedge clk_i);
    drop();
    release_after(TMO_INTERNAL, 16'h0000);
    $display("test restart done");
    timeout_select_i = TMO_LATCH;
    @(negedge clk_i);
    monitors_i = 3'h0;
    repeat (INT_C + 4) @(negedge clk_i);
    check(supply_reset_n_o, 1'h1, "latched high");
    timeout_select_i = TMO_INTERNAL;
    @(negedge clk_i);
    check(supply_reset_n_o, 1'h0, "latch exit");
    timeout_select_i = TMO_LATCH;
    monitors_i = 3'h7;
    repeat (INT_C + 4) @(negedge clk_i);
    check(supply_reset_n_o, 1'h0, "latched low");
    release_after(TMO_INTERNAL, 16'h0000);
    $display("test latch done");
    for (int i = 0; i < 5; i++) begin
      pf_sense_i = pf_seq[i];
      @(negedge clk_i);
      check(power_fail_warn_n_o, warn_exp[i], "warn level");
      check(supply_reset_n_o, 1'h1, "reset untouched");
    end
    @(negedge clk_i);
    check(host.shutdowns == 2, 1'h1, "host shutdowns");
    drop();
    $display("test power fail done");
    results();
  end
endmodule
